// ---- breaker_wear_consts.vh ----
`ifndef BREAKER_WEAR_CONSTS_VH
`define BREAKER_WEAR_CONSTS_VH

// ==========================================
// Register byte addresses
`define A_CTRL    8'h00
`define A_OPS1    8'h04
`define A_OPS2    8'h08
`define A_CUR1    8'h0C
`define A_CUR2    8'h10
`define A_ALM1    8'h14
`define A_ALM2    8'h18
`define A_STAT    8'h1C
`define A_NOPS    8'h20
`define A_CNT1    8'h24
`define A_CNT2    8'h28
`define A_LEFTA   8'h2C
`define A_LEFTB   8'h30
`define A_LEFTC   8'h34
`define A_CMD     8'h38

// ==========================================
// Control fields
`define F_MODE    2:0
`define F_FORCE   5:4
`define F_SIDE    8
`define F_EN1     12
`define F_EN2     13
`define F_TSEL    18:16
`define C_CLR_OPS 0
`define C_CLR_A1  1
`define C_CLR_A2  2
`define C_RELOAD  3

// ==========================================
// Defaults
`define D_OPS1    18'h0C350
`define D_OPS2    18'h00064
`define D_CUR1    14'h0064
`define D_CUR2    14'h07D0
`define D_ALM1    18'h003E8
`define D_ALM2    18'h00064
`define D_SIDE    1'b0
`define D_EN      1'b0
`define D_TSEL    3'h0

// ==========================================
// Modes and forced status
`define M_ON      3'h0
`define M_BLK     3'h1
`define M_TEST    3'h2
`define M_TBLK    3'h3
`define M_OFF     3'h4
`define FS_NORM   2'h0
`define FS_A1     2'h1
`define FS_A2     2'h2

// ==========================================
// Arithmetic
`define ONE_OP    26'h0000100
`define SAT_OP    26'h3FFFFFF
`define EXP_MAX   5'h11
`define DIV_LAST  5'h19
`define PH_LAST   2'h2
`define LG_TOP    5'h11
`endif

// ---- breaker_wear_monitor.v ----
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "breaker_wear_consts.vh"
module breaker_wear_monitor (
   input  wire        clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [7:0]  tripOut,
   input  wire [13:0] phaseAFundamentalCurrentS1,
   input  wire [13:0] phaseBFundamentalCurrentS1,
   input  wire [13:0] phaseCFundamentalCurrentS1,
   input  wire [13:0] phaseAFundamentalCurrentS2,
   input  wire [13:0] phaseBFundamentalCurrentS2,
   input  wire [13:0] phaseCFundamentalCurrentS2,
   input  wire        modeAllow,
   input  wire        forceAllow,
   output wire        alarm1,
   output wire        alarm2,
   output wire        testMode,
   output wire        calcBusy
);

   localparam S_IDLE  = 2'h0;
   localparam S_LOAD  = 2'h1;
   localparam S_DIV   = 2'h2;
   localparam S_APPLY = 2'h3;

   // ==========================================
   // Mitchell log2, 5.8 fixed point
   function [12:0] lg2;
      input [17:0] x;
      integer      i;
      reg   [4:0]  p;
      reg   [17:0] s;
      begin
         p = 5'h00;
         for (i = 0; i < 18; i = i + 1) begin
            if (x[i])
               p = i[4:0];
         end
         s = x << (`LG_TOP - p);
         lg2 = {p, s[16:9]};
      end
   endfunction

   reg  [2:0]  mode_r;
   reg  [1:0]  force_r;
   reg         side_r;
   reg         en1_r;
   reg         en2_r;
   reg  [2:0]  tsel_r;
   reg  [17:0] ops1_r;
   reg  [17:0] ops2_r;
   reg  [13:0] cur1_r;
   reg  [13:0] cur2_r;
   reg  [17:0] set1_r;
   reg  [17:0] set2_r;
   reg  [31:0] nOps_r;
   reg  [31:0] cnt1_r;
   reg  [31:0] cnt2_r;
   reg  [7:0]  tripPrev_r;
   reg  [1:0]  state_r;
   reg  [1:0]  ph_r;
   reg  [4:0]  step_r;
   reg  [25:0] q_r;
   reg  [13:0] rem_r;
   reg  [12:0] den_r;
   reg         unity_r;
   reg         alarm1_r;
   reg         alarm2_r;
   reg         testMode_r;
   reg         busy_r;
   reg  [31:0] prdata_r;
   reg  [31:0] rdMux;
   reg         hit;

   wire [77:0] leftAll;
   wire [41:0] capAll;
   wire [2:0]  below1;
   wire [2:0]  below2;
   wire [2:0]  mode_nxt;

   // ==========================================
   // APB decode; answers in the access cycle
   wire wrEn   = psel & penable & pwrite;
   wire setup  = psel & ~penable;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign prdata  = prdata_r;

   always @* begin
      hit = 1'b1;
      rdMux = 32'h00000000;
      case (paddr)
         `A_CTRL:  rdMux = {13'h0000, tsel_r, 2'h0, en2_r, en1_r, 3'h0, side_r,
                            2'h0, force_r, 1'b0, mode_r};
         `A_OPS1:  rdMux = {14'h0000, ops1_r};
         `A_OPS2:  rdMux = {14'h0000, ops2_r};
         `A_CUR1:  rdMux = {18'h00000, cur1_r};
         `A_CUR2:  rdMux = {18'h00000, cur2_r};
         `A_ALM1:  rdMux = {14'h0000, set1_r};
         `A_ALM2:  rdMux = {14'h0000, set2_r};
         `A_STAT:  rdMux = {23'h000000, testMode, 1'b0, mode_r, 1'b0, calcBusy,
                            alarm2_r, alarm1_r};
         `A_NOPS:  rdMux = nOps_r;
         `A_CNT1:  rdMux = cnt1_r;
         `A_CNT2:  rdMux = cnt2_r;
         `A_LEFTA: rdMux = {14'h0000, leftAll[25:8]};
         `A_LEFTB: rdMux = {14'h0000, leftAll[51:34]};
         `A_LEFTC: rdMux = {14'h0000, leftAll[77:60]};
         `A_CMD:   rdMux = 32'h00000000;
         default:  hit = 1'b0;
      endcase
   end

   always @(posedge clk) begin
      if (rst)
         prdata_r <= 32'h00000000;
      else if (setup & ~pwrite)
         prdata_r <= rdMux;
   end

   // ==========================================
   // Settings; held apart from any setting group
   wire cmdWr  = wrEn & (paddr == `A_CMD);
   wire reload = cmdWr & pwdata[`C_RELOAD];
   // Out-of-range mode codes are dropped
   wire modeWr = wrEn & (paddr == `A_CTRL) & modeAllow & (pwdata[`F_MODE] <= `M_OFF);
   assign mode_nxt = modeWr ? pwdata[`F_MODE] : mode_r;

   always @(posedge clk) begin
      if (rst) begin
         mode_r  <= `M_ON;
         force_r <= `FS_NORM;
         side_r  <= `D_SIDE;
         en1_r   <= `D_EN;
         en2_r   <= `D_EN;
         tsel_r  <= `D_TSEL;
         ops1_r  <= `D_OPS1;
         ops2_r  <= `D_OPS2;
         cur1_r  <= `D_CUR1;
         cur2_r  <= `D_CUR2;
         set1_r  <= `D_ALM1;
         set2_r  <= `D_ALM2;
      end else if (wrEn) begin
         case (paddr)
            `A_CTRL: begin
               if (modeWr)
                  mode_r <= mode_nxt;
               if (forceAllow && pwdata[`F_FORCE] <= `FS_A2)
                  force_r <= pwdata[`F_FORCE];
               side_r <= pwdata[`F_SIDE];
               en1_r  <= pwdata[`F_EN1];
               en2_r  <= pwdata[`F_EN2];
               tsel_r <= pwdata[`F_TSEL];
            end
            `A_OPS1: ops1_r <= pwdata[17:0];
            `A_OPS2: ops2_r <= pwdata[17:0];
            `A_CUR1: cur1_r <= pwdata[13:0];
            `A_CUR2: cur2_r <= pwdata[13:0];
            `A_ALM1: set1_r <= pwdata[17:0];
            `A_ALM2: set2_r <= pwdata[17:0];
            default: ;
         endcase
      end
   end

   // Test flag kept in a flop beside the mode, not decoded at the pin
   always @(posedge clk) begin
      if (rst)
         testMode_r <= 1'b0;
      else
         testMode_r <= (mode_nxt == `M_TEST) | (mode_nxt == `M_TBLK);
   end

   // ==========================================
   // Trigger from selected open command
   wire trigEdge = tripOut[tsel_r] & ~tripPrev_r[tsel_r];
   // A command arriving while busy is lost, not queued
   wire trig     = trigEdge & (mode_r != `M_OFF) & (state_r == S_IDLE);

   always @(posedge clk) begin
      if (rst)
         tripPrev_r <= 8'h00;
      else
         tripPrev_r <= tripOut;
   end

   // ==========================================
   // Per phase capture and remaining count
   wire [12:0] liDiv;
   wire [25:0] cons;

   genvar k;
   generate
      for (k = 0; k < 3; k = k + 1) begin : phase
         reg  [13:0] cap_r;
         reg  [25:0] left_r;
         wire [13:0] s1 = (k == 0) ? phaseAFundamentalCurrentS1 :
                          (k == 1) ? phaseBFundamentalCurrentS1 :
                                     phaseCFundamentalCurrentS1;
         wire [13:0] s2 = (k == 0) ? phaseAFundamentalCurrentS2 :
                          (k == 1) ? phaseBFundamentalCurrentS2 :
                                     phaseCFundamentalCurrentS2;
         always @(posedge clk) begin
            if (rst)
               cap_r <= 14'h0000;
            else if (trig)
               cap_r <= side_r ? s2 : s1;
         end
         always @(posedge clk) begin
            if (rst)
               left_r <= {`D_OPS1, 8'h00};
            else if (reload)
               left_r <= {ops1_r, 8'h00};
            else if (state_r == S_APPLY && ph_r == k) begin
               if (left_r < cons)
                  left_r <= 26'h0000000;
               else
                  left_r <= left_r - cons;
            end
         end
         assign below1[k] = left_r[25:8] < set1_r;
         assign below2[k] = left_r[25:8] < set2_r;
         assign leftAll[26*k+25:26*k] = left_r;
         assign capAll[14*k+13:14*k]  = cap_r;
      end
   endgenerate

   // ==========================================
   // Characteristic evaluation
   // Exponent e = (lgI - lgI1) * (lgN1 - lgN2) / (lgI2 - lgI1)
   wire [13:0] curSel = (ph_r == 2'h0) ? capAll[13:0] :
                        (ph_r == 2'h1) ? capAll[27:14] : capAll[41:28];
   wire [13:0] iClamp = (curSel > cur2_r) ? cur2_r : curSel;
   wire [12:0] li     = lg2({4'h0, iClamp});
   wire [12:0] li1    = lg2({4'h0, cur1_r});
   wire [12:0] li2    = lg2({4'h0, cur2_r});
   wire [12:0] ln1    = lg2(ops1_r);
   wire [12:0] ln2    = lg2(ops2_r);
   wire [12:0] dI     = li - li1;
   wire [12:0] dN     = ln1 - ln2;
   wire [12:0] denW   = li2 - li1;
   wire [25:0] numW   = dI * dN;
   // Degenerate curves and currents at or below point one cost one op
   wire        unityW = (iClamp <= cur1_r) | (cur2_r <= cur1_r) |
                        (ops2_r >= ops1_r) | (li <= li1) | (li2 <= li1);

   // Serial divide: 26 cycles per phase buys a single subtractor
   wire [13:0] divT  = {rem_r[12:0], q_r[25]};
   wire        divGe = divT >= {1'b0, den_r};
   wire [13:0] divR  = divT - {1'b0, den_r};

   assign liDiv = q_r[12:0];
   wire        expSat = (|q_r[25:13]) | (liDiv[12:8] > `EXP_MAX);
   wire [25:0] expVal = {17'h00000, 1'b1, liDiv[7:0]} << liDiv[12:8];
   // Ratio N1/N(I) in 8-bit fraction, so fractions of ops accumulate
   assign cons = unity_r ? `ONE_OP : (expSat ? `SAT_OP : expVal);

   always @(posedge clk) begin
      if (rst) begin
         state_r <= S_IDLE;
         ph_r    <= 2'h0;
         step_r  <= 5'h00;
         q_r     <= 26'h0000000;
         rem_r   <= 14'h0000;
         den_r   <= 13'h0000;
         unity_r <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (trig) begin
                  ph_r    <= 2'h0;
                  state_r <= S_LOAD;
               end
            end
            S_LOAD: begin
               q_r     <= numW;
               den_r   <= denW;
               rem_r   <= 14'h0000;
               step_r  <= 5'h00;
               unity_r <= unityW;
               state_r <= S_DIV;
            end
            S_DIV: begin
               q_r    <= {q_r[24:0], divGe};
               rem_r  <= divGe ? divR : divT;
               step_r <= step_r + 5'h01;
               if (step_r == `DIV_LAST)
                  state_r <= S_APPLY;
            end
            S_APPLY: begin
               if (ph_r == `PH_LAST)
                  state_r <= S_IDLE;
               else begin
                  ph_r    <= ph_r + 2'h1;
                  state_r <= S_LOAD;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Busy from a flop; spans exactly the sequencer's stay outside idle
   always @(posedge clk) begin
      if (rst)
         busy_r <= 1'b0;
      else if (trig)
         busy_r <= 1'b1;
      else if (state_r == S_APPLY && ph_r == `PH_LAST)
         busy_r <= 1'b0;
   end

   // ==========================================
   // Alarm stages and forced status
   wire blocked    = (mode_r == `M_BLK) | (mode_r == `M_TBLK) | (mode_r == `M_OFF);
   wire forcing    = forceAllow & (force_r != `FS_NORM);
   wire raw1       = en1_r & (|below1);
   wire raw2       = en2_r & (|below2);
   wire alarm1_nxt = ~blocked & (forcing ? (force_r == `FS_A1) : raw1);
   wire alarm2_nxt = ~blocked & (forcing ? (force_r == `FS_A2) : raw2);
   wire rise1      = alarm1_nxt & ~alarm1_r;
   wire rise2      = alarm2_nxt & ~alarm2_r;

   always @(posedge clk) begin
      if (rst) begin
         alarm1_r <= 1'b0;
         alarm2_r <= 1'b0;
      end else begin
         alarm1_r <= alarm1_nxt;
         alarm2_r <= alarm2_nxt;
      end
   end

   assign alarm1   = alarm1_r;
   assign alarm2   = alarm2_r;
   assign testMode = testMode_r;
   assign calcBusy = busy_r;

   // ==========================================
   // Cumulative counters; an event in the clear cycle still counts
   wire clrOps = cmdWr & pwdata[`C_CLR_OPS];
   wire clrA1  = cmdWr & pwdata[`C_CLR_A1];
   wire clrA2  = cmdWr & pwdata[`C_CLR_A2];

   always @(posedge clk) begin
      if (rst) begin
         nOps_r <= 32'h00000000;
         cnt1_r <= 32'h00000000;
         cnt2_r <= 32'h00000000;
      end else begin
         if (clrOps)
            nOps_r <= {31'h00000000, trig};
         else if (trig)
            nOps_r <= nOps_r + 32'h00000001;
         if (clrA1)
            cnt1_r <= {31'h00000000, rise1};
         else if (rise1)
            cnt1_r <= cnt1_r + 32'h00000001;
         if (clrA2)
            cnt2_r <= {31'h00000000, rise2};
         else if (rise2)
            cnt2_r <= cnt2_r + 32'h00000001;
      end
   end

endmodule

// ---- breaker_wear_monitor_checker.sv ----
`timescale 1ns/1ps
module breaker_wear_checker (
   input logic        clk,
   input logic        rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic [7:0]  tripOut,
   input logic        forceAllow,
   input logic        alarm1,
   input logic        alarm2,
   input logic        testMode,
   input logic        calcBusy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] tripPrev_r;
   logic [6:0] busyCnt_r;
   logic [1:0] cause_r;
   wire        acc      = psel && penable;
   wire        ctrlWr   = acc && pwrite && (paddr == 8'h00);
   wire        riseAny  = |(tripOut & ~tripPrev_r);
   wire        unmapped = (paddr[1:0] != 2'h0) || (paddr > 8'h38);
   // ==========
   // Helpers
   // Alarm may only rise shortly after a deduction, a write or a force change
   always @(posedge clk) begin
      tripPrev_r <= rst ? 8'h00 : tripOut;
      busyCnt_r  <= (rst || !calcBusy) ? 7'h00 : busyCnt_r + 7'h01;
      if (rst || calcBusy || (acc && pwrite) || $changed(forceAllow))
         cause_r <= 2'h3;
      else if (cause_r != 2'h0)
         cause_r <= cause_r - 2'h1;
   end
   sequence setupRd; psel && !penable && !pwrite; endsequence
   sequence accStat; psel && penable && !pwrite && (paddr == 8'h1C); endsequence
   // ==========
   // Checks
   AST_PREADY: assert property (acc |-> pready)
      else $error("pready low in access");
   AST_SLVERR: assert property (acc |-> (pslverr == unmapped))
      else $error("pslverr does not match address map");
   AST_UNMAP_RD: assert property (acc && !pwrite && unmapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_STAT_RD: assert property (setupRd ##1 accStat |->
      prdata[2:0] == {$past(calcBusy), $past(alarm2), $past(alarm1)})
      else $error("status read wrong");
   AST_PRD_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside read setup");
   AST_BUSY_LEN: assert property ($fell(calcBusy) |-> busyCnt_r == 7'h54)
      else $error("evaluation length not 84 cycles");
   AST_TRIG: assert property ($rose(calcBusy) |-> $past(riseAny))
      else $error("evaluation without open command edge");
   AST_TESTMODE: assert property ($changed(testMode) |-> $past(ctrlWr))
      else $error("test mode moved without control write");
   AST_ALM_CAUSE: assert property ($rose(alarm1) || $rose(alarm2) |-> cause_r != 2'h0)
      else $error("alarm rose without cause");
endmodule

bind breaker_wear_monitor breaker_wear_checker i_breaker_wear_checker (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tripOut(tripOut), .forceAllow(forceAllow), .alarm1(alarm1),
   .alarm2(alarm2), .testMode(testMode), .calcBusy(calcBusy));

// ---- breaker_trip_model.sv ----
`timescale 1ns/1ps
module breaker_trip_model (
   input  logic       clk,
   input  logic       fire,
   input  logic [2:0] chan,
   output logic [7:0] tripOut
);
   // ==========
   // Open command
   // One-cycle pulse so every command gives exactly one rising edge
   initial tripOut = 8'h00;
   always @(posedge clk) tripOut <= fire ? (8'h01 << chan) : 8'h00;
endmodule

// ---- breaker_wear_monitor_test.sv ----
`timescale 1ns/1ps
module breaker_wear_monitor_test;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        fire = 1'b0;
   logic [2:0]  chan = 3'h0;
   logic        modeAllow = 1'b0;
   logic        forceAllow = 1'b0;
   logic [13:0] cur [6] = '{default: 14'h0000};
   logic [31:0] prdata, rdv;
   logic [7:0]  tripOut;
   logic        pready, pslverr, errv, alarm1, alarm2, testMode, calcBusy;
   int          miscompares = 0;
   int          total_checks = 0;
   always #4 clk = ~clk;
   breaker_trip_model i_breaker_trip_model (.clk(clk), .fire(fire), .chan(chan),
      .tripOut(tripOut));
   breaker_wear_monitor i_breaker_wear_monitor (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tripOut(tripOut),
      .phaseAFundamentalCurrentS1(cur[0]), .phaseBFundamentalCurrentS1(cur[1]),
      .phaseCFundamentalCurrentS1(cur[2]), .phaseAFundamentalCurrentS2(cur[3]),
      .phaseBFundamentalCurrentS2(cur[4]), .phaseCFundamentalCurrentS2(cur[5]),
      .modeAllow(modeAllow), .forceAllow(forceAllow), .alarm1(alarm1), .alarm2(alarm2),
      .testMode(testMode), .calcBusy(calcBusy));
   // ==========
   // Shared tasks
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic timeout;
      miscompares++;
      $display("[FAIL] wait limit expected done seen hung");
      end_sim();
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 50) timeout();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rdv);
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic chkAlm(input logic [1:0] e);
      settle();
      chk("alarms", {30'h0, e}, {30'h0, alarm2, alarm1});
   endtask
   // Waits out the whole evaluation; an ignored command leaves busy low
   task automatic trip(input logic [2:0] ch);
      int i;
      @(posedge clk);
      fire <= 1'b1;
      chan <= ch;
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
      for (i = 0; i < 200; i++) begin
         if (calcBusy === 1'b0) break;
         @(posedge clk);
      end
      if (i == 200) timeout();
   endtask
   // ==========
   // Scenarios
   task automatic t_defaults;
      logic [7:0]  ad [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h2C,
                                8'h20, 8'h38};
      logic [31:0] ex [10] = '{32'h0, 32'h0C350, 32'h64, 32'h64, 32'h7D0, 32'h3E8,
                                32'h64, 32'h0C350, 32'h0, 32'h0};
      foreach (ad[k]) rd(ad[k], ex[k]);
      apb(1'b0, 8'h3C, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, errv});
      $display("defaults done");
   endtask
   task automatic t_basic;
      for (int k = 0; k < 6; k++) cur[k] <= (k < 3) ? 14'h0032 : 14'h07D0;
      wr(8'h00, 32'h00020000);
      trip(3'h0);
      rd(8'h20, 32'h0);
      trip(3'h2);
      rd(8'h20, 32'h1);
      for (int k = 0; k < 3; k++) rd(8'h2C + 8'(4 * k), 32'h0C34F);
      $display("basic done");
   endtask
   // Four ops at point one, one at point two: full current costs exactly four
   task automatic t_curve;
      wr(8'h04, 32'h4);
      wr(8'h08, 32'h1);
      wr(8'h10, 32'hC8);
      wr(8'h38, 32'h8);
      wr(8'h00, 32'h00020100);
      for (int k = 0; k < 6; k++) cur[k] <= (k < 4) ? 14'h00C8 : ((k == 4) ? 14'h0064 : 14'h0);
      for (int p = 0; p < 2; p++) begin
         trip(3'h2);
         rd(8'h2C, 32'h0);
         rd(8'h30, 32'(3 - p));
         rd(8'h34, 32'(3 - p));
      end
      $display("curve done");
   endtask
   task automatic t_alarms;
      wr(8'h14, 32'h3);
      wr(8'h18, 32'h1);
      chkAlm(2'b00);
      wr(8'h00, 32'h00023100);
      chkAlm(2'b11);
      wr(8'h14, 32'h0);
      chkAlm(2'b10);
      rd(8'h24, 32'h1);
      rd(8'h28, 32'h1);
      wr(8'h38, 32'h7);
      rd(8'h24, 32'h0);
      rd(8'h28, 32'h0);
      rd(8'h20, 32'h0);
      $display("alarms done");
   endtask
   task automatic t_modes;
      logic [1:0] ex;
      wr(8'h00, 32'h00023101);
      rd(8'h1C, 32'h2);
      modeAllow <= 1'b1;
      for (int m = 0; m < 5; m++) begin
         wr(8'h00, 32'h00023100 | m);
         settle();
         ex = {m == 2 || m == 3, m == 0 || m == 2};
         chk("mode outputs", {30'h0, ex}, {30'h0, testMode, alarm2});
      end
      trip(3'h2);
      rd(8'h20, 32'h0);
      wr(8'h00, 32'h00023105);
      rd(8'h00, 32'h00023104);
      wr(8'h00, 32'h00023110);
      rd(8'h00, 32'h00023100);
      forceAllow <= 1'b1;
      wr(8'h00, 32'h00023110);
      chkAlm(2'b01);
      wr(8'h00, 32'h00021120);
      chkAlm(2'b10);
      $display("modes done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_basic();
      t_curve();
      t_alarms();
      t_modes();
      end_sim();
   end
endmodule
